// *** src/ddrecc_top.sv ***
`include "ddrecc_consts.svh"
module ddrecc_top
  import ddrecc_pkg::*;
#(
  parameter int RANKS = 4,
  parameter int ADDR_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ecc_multi_err,
  input wire logic ecc_single_err,
  input wire logic [31:0] ecc_err_addr,
  input wire logic core_read_fault_enable,
  output logic core_fault_req,
  output logic irq,
  output logic [ADDR_W-1:0] memory_address_lines_o,
  output logic memory_address_lines_oe_n,
  output logic [RANKS-1:0] rank_select_n,
  output logic [RANKS-1:0] rank_clock_enable,
  output logic [RANKS-1:0] rank_termination_enable
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] memory_controller_config_reg;
  logic [31:0] error_detect_mask_reg;
  logic [31:0] int_enable_reg;
  logic [2:0] status_reg;
  logic [2:0] mask_reg;
  logic [31:0] capt_reg;
  logic [31:0] cmd_reg;
  logic cmd_pulse_reg;
  logic core_fault_reg;
  logic irq_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_fire;
  logic rd_fire;
  logic rd_status;
  logic ecc_on;
  logic mbe_detect;
  logic mbe_report;
  logic sbe_report;
  logic cmd_busy;
  logic cmd_done;
  logic cmd_busy_d_reg;
  logic [31:0] wr_merged;
  logic [31:0] mask_merged;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data may arrive in either order.
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      // Unmapped offsets answer with a slave error and change no register.
      case (aw_addr_reg)
        `DDRECC_CFG_ADDR, `DDRECC_ERRMASK_ADDR, `DDRECC_INTEN_ADDR,
        `DDRECC_STATUS_ADDR, `DDRECC_MASK_ADDR, `DDRECC_CMD_ADDR,
        `DDRECC_CAPT_ADDR: bresp_reg <= 2'h0;
        default: bresp_reg <= 2'h2;
      endcase
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  assign wr_merged = merge(32'h0000_0000, w_data_reg, w_strb_reg);
  // Only three mask bits exist, so the upper part of the merged word is dropped on purpose.
  assign mask_merged = merge({29'h0, mask_reg}, w_data_reg, w_strb_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Software-steered configuration.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      memory_controller_config_reg <= `DDRECC_CFG_RESET;
      error_detect_mask_reg <= `DDRECC_ERRMASK_RESET;
      int_enable_reg <= `DDRECC_INTEN_RESET;
      mask_reg <= 3'(`DDRECC_MASK_RESET);
    end else if (wr_fire) begin
      case (aw_addr_reg)
        `DDRECC_CFG_ADDR: memory_controller_config_reg <=
            merge(memory_controller_config_reg, w_data_reg, w_strb_reg);
        `DDRECC_ERRMASK_ADDR: error_detect_mask_reg <= merge(error_detect_mask_reg, w_data_reg, w_strb_reg);
        `DDRECC_INTEN_ADDR: int_enable_reg <= merge(int_enable_reg, w_data_reg, w_strb_reg);
        `DDRECC_MASK_ADDR: mask_reg <= mask_merged[2:0];
        default: begin
        end
      endcase
    end
  end

  // A write to the command register schedules one slot on the address bus while the memory enable bit is set.
  // A write that arrives while a slot still runs is dropped, not queued, so
  // software must poll the busy bit before it issues the next command.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_reg <= 32'h0000_0000;
      cmd_pulse_reg <= 1'b0;
    end else begin
      cmd_pulse_reg <= wr_fire && (aw_addr_reg == `DDRECC_CMD_ADDR) && !cmd_busy;
      if (wr_fire && (aw_addr_reg == `DDRECC_CMD_ADDR) && !cmd_busy) begin
        cmd_reg <= wr_merged;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error qualification. The error inputs are same-clock strobes from the
  // read data path, so they are used without synchronisers.
  assign ecc_on = memory_controller_config_reg[`DDRECC_CFG_ECC_EN];
  assign mbe_detect = ecc_multi_err && ecc_on && !error_detect_mask_reg[`DDRECC_MULTIBIT_ERROR_DISABLE];
  assign mbe_report = mbe_detect && int_enable_reg[`DDRECC_MULTIBIT_INTERRUPT_ENABLE];
  assign sbe_report = ecc_single_err && ecc_on;
  assign cmd_done = cmd_busy_d_reg && !cmd_busy;

  // The core fault pulse follows every detected uncorrectable error; the core
  // itself decides, via its read-fault enable, whether it becomes a machine check.
  // That enable is therefore not used here: gating the request in the controller
  // as well would hide errors from a core that records them without trapping.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_fault_reg <= 1'b0;
      cmd_busy_d_reg <= 1'b0;
    end else begin
      core_fault_reg <= mbe_detect;
      cmd_busy_d_reg <= cmd_busy;
    end
  end

  assign core_fault_req = core_fault_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capt_reg <= 32'h0000_0000;
    end else if (mbe_detect) begin
      capt_reg <= ecc_err_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, cleared by reading it; a new event in that cycle wins.
  // The read data hold the old value, so such an event is kept for the next
  // read instead of being lost between the capture and the clear.
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_status = rd_fire && (s_axi_araddr == `DDRECC_STATUS_ADDR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= 3'h0;
    end else begin
      status_reg[`DDRECC_ST_MBE] <= mbe_report || (status_reg[`DDRECC_ST_MBE] && !rd_status);
      status_reg[`DDRECC_ST_SBE] <= sbe_report || (status_reg[`DDRECC_ST_SBE] && !rd_status);
      status_reg[`DDRECC_ST_CMD] <= cmd_done || (status_reg[`DDRECC_ST_CMD] && !rd_status);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read: one cycle after the address is taken.
  assign s_axi_arready = !rvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= 2'h0;
      case (s_axi_araddr)
        `DDRECC_CFG_ADDR: rdata_reg <= memory_controller_config_reg;
        `DDRECC_ERRMASK_ADDR: rdata_reg <= error_detect_mask_reg;
        `DDRECC_INTEN_ADDR: rdata_reg <= int_enable_reg;
        `DDRECC_STATUS_ADDR: rdata_reg <= {29'h0, status_reg};
        `DDRECC_MASK_ADDR: rdata_reg <= {29'h0, mask_reg};
        `DDRECC_CMD_ADDR: rdata_reg <= {cmd_busy, cmd_reg[30:0]};
        `DDRECC_CAPT_ADDR: rdata_reg <= capt_reg;
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Command word: address in [15:0], rank in [17:16]. Clock enables follow the
  // memory enable bit; termination is asserted for the addressed rank only.
  ddrecc_cmd_drive #(
    .RANKS(RANKS),
    .ADDR_W(ADDR_W)
  ) u_cmd (
    .aclk(aclk),
    .aresetn(aresetn),
    .cmd_start(cmd_pulse_reg && memory_controller_config_reg[`DDRECC_CFG_MEM_EN]),
    .cmd_addr(cmd_reg[ADDR_W-1:0]),
    .cmd_rank(cmd_reg[16 +: $clog2(RANKS)]),
    .rank_on({RANKS{memory_controller_config_reg[`DDRECC_CFG_MEM_EN]}}),
    .rank_odt(~rank_select_n),
    .cmd_busy(cmd_busy),
    .memory_address_lines_o(memory_address_lines_o),
    .memory_address_lines_oe_n(memory_address_lines_oe_n),
    .rank_select_n(rank_select_n),
    .rank_clock_enable(rank_clock_enable),
    .rank_termination_enable(rank_termination_enable)
  );
endmodule : ddrecc_top

// *** src/ddrecc_consts.svh ***
`ifndef DDRECC_CONSTS_SVH
`define DDRECC_CONSTS_SVH
// Register byte addresses on the AXI4-Lite bus.
`define DDRECC_CFG_ADDR 8'h00
`define DDRECC_ERRMASK_ADDR 8'h04
`define DDRECC_INTEN_ADDR 8'h08
`define DDRECC_STATUS_ADDR 8'h0c
`define DDRECC_MASK_ADDR 8'h10
`define DDRECC_CMD_ADDR 8'h14
`define DDRECC_CAPT_ADDR 8'h18
// Field positions.
`define DDRECC_CFG_MEM_EN 31
`define DDRECC_CFG_ECC_EN 2
`define DDRECC_CFG_NARROW 3
`define DDRECC_CFG_EIGHT_BEAT 4
`define DDRECC_CFG_DRIVE_SEL 5
`define DDRECC_CFG_GEN_LSB 24
`define DDRECC_MULTIBIT_ERROR_DISABLE 28
`define DDRECC_MULTIBIT_INTERRUPT_ENABLE 28
`define DDRECC_ST_MBE 0
`define DDRECC_ST_SBE 1
`define DDRECC_ST_CMD 2
// Reset values.
`define DDRECC_CFG_RESET 32'h0000_0000
`define DDRECC_ERRMASK_RESET 32'h0000_0000
`define DDRECC_INTEN_RESET 32'h0000_0000
`define DDRECC_MASK_RESET 32'h0000_0000
// Memory generation codes.
`define DDRECC_GEN_DDR1 3'h2
`define DDRECC_GEN_DDR2 3'h3
// Command slot length on the address bus, in ns, and in cycles at 200 MHz.
`define DDRECC_CMD_NS 5
`define DDRECC_CLK_NS 5
`define DDRECC_CMD_CYC ((`DDRECC_CMD_NS + `DDRECC_CLK_NS - 1) / `DDRECC_CLK_NS)
`endif

// *** src/ddrecc_pkg.sv ***
package ddrecc_pkg;
  typedef enum logic [1:0] {DDRECC_IDLE, DDRECC_DRIVE, DDRECC_HOLD} ddrecc_cmd_state_t;
  typedef enum logic [1:0] {DDRECC_RD_IDLE, DDRECC_RD_RESP} ddrecc_rd_state_t;
endpackage : ddrecc_pkg

// *** src/ddrecc_cmd_drive.sv ***
`include "ddrecc_consts.svh"
module ddrecc_cmd_drive
  import ddrecc_pkg::*;
#(
  parameter int RANKS = 4,
  parameter int ADDR_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cmd_start,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [$clog2(RANKS)-1:0] cmd_rank,
  input wire logic [RANKS-1:0] rank_on,
  input wire logic [RANKS-1:0] rank_odt,
  output logic cmd_busy,
  output logic [ADDR_W-1:0] memory_address_lines_o,
  output logic memory_address_lines_oe_n,
  output logic [RANKS-1:0] rank_select_n,
  output logic [RANKS-1:0] rank_clock_enable,
  output logic [RANKS-1:0] rank_termination_enable
);
  ddrecc_cmd_state_t state_reg;
  logic [7:0] cnt_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [$clog2(RANKS)-1:0] rank_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= DDRECC_IDLE;
      cnt_reg <= 8'h00;
      addr_reg <= '0;
      rank_reg <= '0;
    end else begin
      case (state_reg)
        DDRECC_IDLE: begin
          if (cmd_start) begin
            state_reg <= DDRECC_DRIVE;
            addr_reg <= cmd_addr;
            rank_reg <= cmd_rank;
            cnt_reg <= 8'((`DDRECC_CMD_CYC) - 1);
          end
        end
        DDRECC_DRIVE: begin
          if (cnt_reg == 8'h00) begin
            state_reg <= DDRECC_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: state_reg <= DDRECC_IDLE;
      endcase
    end
  end

  // Address lines float except during a scheduled command slot.
  assign memory_address_lines_o = addr_reg;
  assign memory_address_lines_oe_n = (state_reg != DDRECC_DRIVE);
  assign cmd_busy = (state_reg != DDRECC_IDLE);

  // Rank n's clock enable, chip select and termination share index n.
  genvar g;
  generate
    for (g = 0; g < RANKS; g++) begin : g_rank
      assign rank_select_n[g] = !((state_reg == DDRECC_DRIVE) && (rank_reg == g));
      assign rank_clock_enable[g] = rank_on[g];
      assign rank_termination_enable[g] = rank_odt[g];
    end
  endgenerate
endmodule : ddrecc_cmd_drive

// *** sim/ddrecc_dram_model.sv ***
module ddrecc_dram_model #(
  parameter int RANKS = 4,
  parameter int ADDR_W = 16
) (
  input wire logic aclk,
  input wire logic mem_rst_n,
  input wire logic [ADDR_W-1:0] addr_pins,
  input wire logic [RANKS-1:0] rank_select_n,
  input wire logic [RANKS-1:0] rank_clock_enable,
  input wire logic [RANKS-1:0] rank_termination_enable,
  output int cmd_count,
  output logic [ADDR_W-1:0] last_addr,
  output int last_rank,
  output int faults
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cmd_count = 0;
    faults = 0;
  end
  // A rank latches every command it is selected for; one seen in reset, without its own enables or from a floating bus counts as a fault.
  always @(posedge aclk) begin
    for (int r = 0; r < RANKS; r++) begin
      if (!rank_select_n[r]) begin
        if (!mem_rst_n || !rank_clock_enable[r] || !rank_termination_enable[r] || $isunknown(addr_pins)) begin
          faults++;
        end
        last_addr = addr_pins;
        last_rank = r;
        cmd_count++;
      end
    end
  end
endmodule : ddrecc_dram_model

// *** sim/ddrecc_monitor.sv ***
module ddrecc_monitor #(parameter int RANKS = 4) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ecc_multi_err,
  input wire logic ecc_single_err,
  input wire logic core_read_fault_enable,
  input wire logic core_fault_req,
  input wire logic irq,
  input wire logic memory_address_lines_oe_n,
  input wire logic [RANKS-1:0] rank_select_n,
  input wire logic [RANKS-1:0] rank_clock_enable,
  input wire logic [RANKS-1:0] rank_termination_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  // Cycles since the last thing that may set a status bit or change the mask.
  wire irq_cause = ecc_multi_err || ecc_single_err || !memory_address_lines_oe_n || (s_axi_wvalid && s_axi_wready);
  logic [2:0] quiet_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || irq_cause) begin
      quiet_reg <= 3'h0;
    end else if (quiet_reg != 3'h7) begin
      quiet_reg <= quiet_reg + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_slot_open; $fell(memory_address_lines_oe_n); endsequence
  sequence s_slot_close; memory_address_lines_oe_n && (&rank_select_n); endsequence
  property p_slot_len; s_slot_open |=> s_slot_close; endproperty
  a_slot_len: assert property (p_slot_len) else $error("address slot too long");
  property p_drive_sel; !memory_address_lines_oe_n |-> $onehot(~rank_select_n); endproperty
  a_drive_sel: assert property (p_drive_sel) else $error("address driven without one rank");
  property p_float_idle; (&rank_select_n) |-> memory_address_lines_oe_n; endproperty
  a_float_idle: assert property (p_float_idle) else $error("address driven while idle");
  property p_odt_pair; rank_termination_enable == ~rank_select_n; endproperty
  a_odt_pair: assert property (p_odt_pair) else $error("termination index differs from select");
  property p_cke_pair; !(&rank_select_n) |-> (&rank_clock_enable); endproperty
  a_cke_pair: assert property (p_cke_pair) else $error("rank selected without clock enable");
  property p_fault; core_fault_req |-> $past(ecc_multi_err); endproperty
  a_fault: assert property (p_fault) else $error("fault request without cause");
  property p_irq; $rose(irq) |-> quiet_reg < 3'h6; endproperty
  a_irq: assert property (p_irq) else $error("interrupt rose without event");
  property p_rdata_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read answer dropped or changed");
endmodule : ddrecc_monitor

bind ddrecc_top ddrecc_monitor #(.RANKS(RANKS)) i_ddrecc_monitor (
  .aclk, .aresetn, .s_axi_wvalid, .s_axi_wready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ecc_multi_err,
  .ecc_single_err, .core_read_fault_enable, .core_fault_req, .irq, .memory_address_lines_oe_n, .rank_select_n,
  .rank_clock_enable, .rank_termination_enable
);

// *** sim/test_ddrecc_top.sv ***
`include "ddrecc_consts.svh"
module test_ddrecc_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ecc_multi_err = 1'b0, ecc_single_err = 1'b0;
  logic core_read_fault_enable = 1'b0, mem_rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, ecc_err_addr = 32'h0, a, st, capt = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, core_fault_req, irq, f;
  logic memory_address_lines_oe_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] rank_select_n, rank_clock_enable, rank_termination_enable;
  logic [15:0] memory_address_lines_o, last_addr;
  logic [31:0] s_axi_rdata;
  int n_errors = 0, samples_checked = 0, cmd_count, last_rank, faults;
  // Nothing holds the address bus when the controller lets go, so it floats.
  wire [15:0] ma_wire = memory_address_lines_oe_n ? 16'hzzzz : memory_address_lines_o;

  always #2.5 aclk = ~aclk;

  ddrecc_top #(.RANKS(4), .ADDR_W(16)) i_ddrecc_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ecc_multi_err, .ecc_single_err, .ecc_err_addr,
    .core_read_fault_enable, .core_fault_req, .irq, .memory_address_lines_o, .memory_address_lines_oe_n,
    .rank_select_n, .rank_clock_enable, .rank_termination_enable
  );
  ddrecc_dram_model i_dram (.aclk, .mem_rst_n, .addr_pins(ma_wire), .rank_select_n, .rank_clock_enable,
    .rank_termination_enable, .cmd_count, .last_addr, .last_rank, .faults);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Ready for the answer is raised late at random so that a slow master is exercised.
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int k;
    k = $urandom_range(2);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (k-- == 0) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er = 2'h0);
    int k;
    k = $urandom_range(2);
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (k-- == 0) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    chk("rresp", er, s_axi_rresp);
    chk("rdata", e, s_axi_rdata);
  endtask : rd

  task automatic err(input logic [31:0] ad);
    @(posedge aclk);
    ecc_multi_err <= 1'b1;
    ecc_single_err <= 1'b1;
    ecc_err_addr <= ad;
    @(posedge aclk);
    ecc_multi_err <= 1'b0;
    ecc_single_err <= 1'b0;
    ecc_err_addr <= ~ad;
    f = 1'b0;
    repeat (3) begin
      @(posedge aclk);
      f |= core_fault_req;
    end
  endtask : err

  task automatic final_report();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(47520));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
    rd(8'h1c, 32'h0, 2'h2);
    wr(8'h1c, 32'hffff_ffff, 2'h2);
    wr(`DDRECC_MASK_ADDR, 32'h1);
    for (int i = 0; i < 16; i++) begin
      wr(`DDRECC_CFG_ADDR, 32'(i[0]) << `DDRECC_CFG_ECC_EN);
      wr(`DDRECC_ERRMASK_ADDR, 32'(i[1]) << `DDRECC_MULTIBIT_ERROR_DISABLE);
      wr(`DDRECC_INTEN_ADDR, 32'(i[2]) << `DDRECC_MULTIBIT_INTERRUPT_ENABLE);
      core_read_fault_enable <= i[3];
      a = $urandom;
      if (i[0] && !i[1]) capt = a;
      st = {30'h0, i[0], i[0] && !i[1] && i[2]};
      err(a);
      chk("fault", i[0] && !i[1], f);
      chk("irq", st[0], irq);
      rd(`DDRECC_STATUS_ADDR, st);
      repeat (3) @(posedge aclk);
      chk("irq_clear", 32'h0, irq);
      rd(`DDRECC_CAPT_ADDR, capt);
    end
    for (int j = 0; j < 3; j++) begin
      a = {5'h0, j == 2 ? `DDRECC_GEN_DDR2 : `DDRECC_GEN_DDR1, 19'h0, j == 0, j != 1, 3'h0};
      wr(`DDRECC_CFG_ADDR, a);
      rd(`DDRECC_CFG_ADDR, a);
    end
    mem_rst_n <= 1'b1;
    wr(`DDRECC_CFG_ADDR, 32'h8000_0000);
    for (int r = 0; r < 4; r++) begin
      a = $urandom;
      wr(`DDRECC_CMD_ADDR, {14'h0, 2'(r), a[15:0]});
      for (int k = 0; k < 20 && memory_address_lines_oe_n !== 1'b0; k++) @(posedge aclk);
      chk("addr", a[15:0], ma_wire);
      chk("cs_n", 4'(~(4'h1 << r)), rank_select_n);
      chk("odt", 4'(4'h1 << r), rank_termination_enable);
      chk("cke", 4'hf, rank_clock_enable);
      rd(`DDRECC_STATUS_ADDR, 32'h4);
      chk("model_rank", r, last_rank);
      chk("model_addr", a[15:0], last_addr);
    end
    wr(`DDRECC_CFG_ADDR, 32'h0);
    wr(`DDRECC_CMD_ADDR, 32'h1_0055);
    repeat (10) @(posedge aclk);
    chk("cmd_count", 4, cmd_count);
    chk("cke_off", 4'h0, rank_clock_enable);
    chk("model_faults", 0, faults);
    final_report();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    final_report();
  end
endmodule : test_ddrecc_top
